// File: hdl/mgmt_regs_pkg.sv
// Constants for the per-port management register subset.
// Assumes a serial management controller on the clock and data pins.
// Summary of operation
// - Status bit 2 reads 1 while the port link is up, 0 after reset.
// - Status bits 1 and 0 always read 0.
// - Register 2 returns the fixed upper identifier; writes ignored.
// - Register 3 returns the fixed lower identifier; writes ignored.
// - Advert bit 10 is writable, resets to 1, offers pause when set.
// - Advert bit 8 is writable, resets to 1, offers 100 full duplex.
// - Advert bit 7 is writable, resets to 1, offers 100 half duplex.
// - Advert bit 6 is writable, resets to 1, offers 10 full duplex.
// - Advert bit 5 is writable, resets to 1, offers 10 half duplex.
// - Advert bits 4 to 0 always read 00001.
// - Partner bit 10 shows partner pause ability, resets to 0.
// - Partner bit 8 shows partner 100 full duplex, resets to 0.
// - Partner bit 7 shows partner 100 half duplex, resets to 0.
// - Partner bit 6 shows partner 10 full duplex, resets to 0.
// - Partner bit 5 shows partner 10 half duplex, resets to 0.
// - All other partner bits always read 0.
// - Ports answer addresses 1 to 5; only registers 0 to 5 exist.
package mgmt_regs_pkg;
   localparam int NUM_PORTS     = 5;
   localparam int PREAMBLE_ONES = 32;
   localparam int HDR_BITS      = 13;
   localparam int DATA_BITS     = 16;

   localparam logic [4:0] REG_CONTROL     = 5'h00;
   localparam logic [4:0] REG_STATUS      = 5'h01;
   localparam logic [4:0] REG_IDENT_UPPER = 5'h02;
   localparam logic [4:0] REG_IDENT_LOWER = 5'h03;
   localparam logic [4:0] REG_ADVERT      = 5'h04;
   localparam logic [4:0] REG_PARTNER     = 5'h05;
   localparam logic [4:0] REG_LAST        = 5'h05;

   localparam logic [4:0] PORT_ADDR_FIRST = 5'h01;
   localparam logic [4:0] PORT_ADDR_LAST  = 5'h05;

   localparam logic [1:0] OP_READ  = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;

   localparam int STATUS_LINK_BIT = 2;
   localparam int ABIL_PAUSE_BIT  = 10;
   localparam int ABIL_100FD_BIT  = 8;
   localparam int ABIL_100HD_BIT  = 7;
   localparam int ABIL_10FD_BIT   = 6;
   localparam int ABIL_10HD_BIT   = 5;

   localparam logic [15:0] ADV_WRITE_MASK = 16'h05e0;
   localparam logic [15:0] ADV_RESET      = 16'h05e1;
   localparam logic [4:0]  ADV_SELECTOR   = 5'h01;
   localparam logic [15:0] PARTNER_MASK   = 16'h05e0;
   localparam logic [15:0] PARTNER_RESET  = 16'h0000;

   typedef enum logic [1:0] {HUNT, HEADER, TURN, DATA} mgmt_state_t;
endpackage

// File: hdl/mgmt_sync2.sv
// Two-stage synchroniser for asynchronous pin levels.
// Assumes inputs may change at any time relative to clk_in.
`timescale 1ns/1ps
module mgmt_sync2 #(
   parameter int W = 1
)(
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   // Levels
   input  wire logic [W-1:0] d_in,
   output logic [W-1:0]      q_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         meta_r <= '0;
         sync_r <= '0;
      end
      else
      begin
         meta_r <= d_in;
         sync_r <= meta_r;
      end
   end

   assign q_out = sync_r;
endmodule

// File: hdl/mdc_edge_detect.sv
// Rising edge finder for the synchronised management clock.
// Assumes level_in is already synchronised to clk_in.
`timescale 1ns/1ps
module mdc_edge_detect (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rstn_in,
   // Level and edge
   input  wire logic level_in,
   output logic      rise_out
);
   logic prev_r;

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         prev_r <= 1'b0;
      else
         prev_r <= level_in;
   end

   // Same cycle as the data sample, so data stays aligned
   assign rise_out = level_in & ~prev_r;
endmodule

// File: hdl/mgmt_port_regs.sv
// Management register slave for five ports over the serial pins.
// Assumes port state inputs come from logic on clk_in.
`timescale 1ns/1ps
module mgmt_port_regs
   import mgmt_regs_pkg::*;
#(
   parameter logic [15:0] IDENT_UPPER = 16'h5a3c, // Arbitrary value
   parameter logic [15:0] IDENT_LOWER = 16'hc3a0  // Arbitrary value
)(
   // Clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   rstn_in,
   // Management pins
   input  wire logic                   mdc_in,
   input  wire logic                   mdio_in,
   output logic                        mdio_out,
   output logic                        mdio_oe_out,
   // Port state from the transceivers
   input  wire logic [NUM_PORTS-1:0]    link_up_in,
   input  wire logic [NUM_PORTS-1:0]    partner_page_valid_in,
   input  wire logic [NUM_PORTS*16-1:0] partner_page_in,
   // Abilities offered during auto-negotiation
   output logic [NUM_PORTS*16-1:0]      local_advert_out
);
   typedef struct packed {
      mgmt_state_t                 st;
      logic [5:0]                  ones;
      logic [4:0]                  cnt;
      logic [12:0]                 hdr;
      logic                        hit;
      logic                        rd;
      logic [15:0]                 sh;
      logic                        out;
      logic                        oe;
      logic [NUM_PORTS-1:0]        lnk;
      logic [NUM_PORTS-1:0][15:0]  adv;
      logic [NUM_PORTS-1:0][15:0]  lp;
   } regs_state_t;

   localparam regs_state_t STATE_RESET = '{
      st:   HUNT,
      ones: 6'h00,
      cnt:  5'h00,
      hdr:  13'h0000,
      hit:  1'b0,
      rd:   1'b0,
      sh:   16'h0000,
      out:  1'b0,
      oe:   1'b0,
      lnk:  '0,
      adv:  {NUM_PORTS{ADV_RESET}},
      lp:   {NUM_PORTS{PARTNER_RESET}}
   };

   regs_state_t state_r;
   regs_state_t state_nxt;
   logic        mdc_s;
   logic        mdio_s;
   logic        mdc_rise;
   logic        ld;
   logic        hdr_done;
   logic        wr_commit;
   logic [15:0] wr_data;
   logic [2:0]  cur_pidx;
   logic [4:0]  cur_reg;

   // Pins cross into clk_in through two flops
   mgmt_sync2 #(
      .W (2)
   ) u_sync (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .d_in    ({mdc_in, mdio_in}),
      .q_out   ({mdc_s, mdio_s})
   );

   mdc_edge_detect u_edge (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .level_in (mdc_s),
      .rise_out (mdc_rise)
   );

   function automatic logic [2:0] port_index(input logic [4:0] addr);
      logic [4:0] d;
      d = addr - PORT_ADDR_FIRST;
      return d[2:0];
   endfunction

   // Start bit, opcode, port and register all must match
   function automatic logic frame_hit(input logic [12:0] h);
      logic ok;
      ok = h[12] && (h[11:10] == OP_READ || h[11:10] == OP_WRITE);
      ok = ok && h[9:5] >= PORT_ADDR_FIRST && h[9:5] <= PORT_ADDR_LAST;
      ok = ok && h[4:0] <= REG_LAST;
      return ok;
   endfunction

   function automatic logic [15:0] read_word(input regs_state_t s,
                                             input logic [2:0]  p,
                                             input logic [4:0]  r);
      logic [15:0] w;
      w = 16'h0000;
      unique case (r)
         REG_STATUS:      w[STATUS_LINK_BIT] = s.lnk[p];
         REG_IDENT_UPPER: w = IDENT_UPPER;
         REG_IDENT_LOWER: w = IDENT_LOWER;
         REG_ADVERT:      w = s.adv[p];
         REG_PARTNER:     w = s.lp[p];
         default:         w = 16'h0000;
      endcase
      return w;
   endfunction

   assign cur_pidx = port_index(state_r.hdr[9:5]);
   assign cur_reg  = state_r.hdr[4:0];
   assign wr_data  = {state_r.sh[14:0], mdio_s};

   always_comb
   begin
      state_nxt = state_r;
      ld        = 1'b0;
      hdr_done  = 1'b0;
      wr_commit = 1'b0;
      state_nxt.lnk = link_up_in;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         if (partner_page_valid_in[p])
            state_nxt.lp[p] = partner_page_in[p*16 +: 16]
                              & PARTNER_MASK;
      end
      if (mdc_rise)
      begin
         unique case (state_r.st)
            HUNT:
            begin
               if (mdio_s)
               begin
                  if (state_r.ones != 6'(PREAMBLE_ONES))
                     state_nxt.ones = state_r.ones + 6'h01;
               end
               else
               begin
                  state_nxt.ones = 6'h00;
                  if (state_r.ones == 6'(PREAMBLE_ONES))
                  begin
                     state_nxt.st  = HEADER;
                     state_nxt.cnt = 5'h00;
                  end
               end
            end
            HEADER:
            begin
               state_nxt.hdr = {state_r.hdr[11:0], mdio_s};
               state_nxt.cnt = state_r.cnt + 5'h01;
               if (state_r.cnt == 5'(HDR_BITS - 1))
               begin
                  hdr_done      = 1'b1;
                  state_nxt.hit = frame_hit(state_nxt.hdr);
                  state_nxt.rd  = state_nxt.hdr[11:10] == OP_READ;
                  state_nxt.st  = TURN;
                  state_nxt.cnt = 5'h00;
               end
            end
            TURN:
            begin
               state_nxt.cnt = state_r.cnt + 5'h01;
               if (state_r.cnt == 5'h00)
               begin
                  // Drive the second turnaround bit low
                  if (state_r.hit && state_r.rd)
                  begin
                     ld            = 1'b1;
                     state_nxt.oe  = 1'b1;
                     state_nxt.out = 1'b0;
                     state_nxt.sh  = read_word(state_r, cur_pidx, cur_reg);
                  end
               end
               else
               begin
                  state_nxt.st  = DATA;
                  state_nxt.cnt = 5'h00;
                  if (state_r.hit && state_r.rd)
                  begin
                     state_nxt.out = state_r.sh[15];
                     state_nxt.sh  = {state_r.sh[14:0], 1'b0};
                  end
               end
            end
            DATA:
            begin
               state_nxt.cnt = state_r.cnt + 5'h01;
               if (state_r.rd)
               begin
                  if (state_r.cnt == 5'(DATA_BITS - 1))
                  begin
                     state_nxt.oe  = 1'b0;
                     state_nxt.out = 1'b0;
                  end
                  else
                  begin
                     state_nxt.out = state_r.sh[15];
                     state_nxt.sh  = {state_r.sh[14:0], 1'b0};
                  end
               end
               else
                  state_nxt.sh = wr_data;
               if (state_r.cnt == 5'(DATA_BITS - 1))
               begin
                  state_nxt.st   = HUNT;
                  state_nxt.ones = 6'h00;
                  // Only the ability bits take writes; identifiers stay
                  if (!state_r.rd && state_r.hit && cur_reg == REG_ADVERT)
                  begin
                     wr_commit = 1'b1;
                     state_nxt.adv[cur_pidx] =
                        (state_r.adv[cur_pidx] & ~ADV_WRITE_MASK)
                        | (wr_data & ADV_WRITE_MASK);
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         state_r <= STATE_RESET;
      else
         state_r <= state_nxt;
   end

   assign mdio_out         = state_r.out;
   assign mdio_oe_out      = state_r.oe;
   assign local_advert_out = state_r.adv;

   // Checking helpers
   logic cur_link;
   logic sel_ok;
   logic lp_zero_ok;

   assign cur_link = state_r.lnk[cur_pidx];

   always_comb
   begin
      sel_ok     = 1'b1;
      lp_zero_ok = 1'b1;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         if (state_r.adv[p][4:0] != ADV_SELECTOR)
            sel_ok = 1'b0;
         if ((state_r.lp[p] & ~PARTNER_MASK) != 16'h0000)
            lp_zero_ok = 1'b0;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   property p_link_status;
      ld && cur_reg == REG_STATUS
         |=> state_r.sh[STATUS_LINK_BIT] == $past(cur_link);
   endproperty
   a_link_status: assert property (p_link_status)
      else $error("status link bit does not follow port link");

   property p_status_fixed;
      ld && cur_reg == REG_STATUS |=> state_r.sh[1:0] == 2'h0;
   endproperty
   a_status_fixed: assert property (p_status_fixed)
      else $error("status low bits not zero");

   property p_ident_upper;
      ld && cur_reg == REG_IDENT_UPPER |=> state_r.sh == IDENT_UPPER;
   endproperty
   a_ident_upper: assert property (p_ident_upper)
      else $error("upper identifier wrong");

   property p_ident_lower;
      ld && cur_reg == REG_IDENT_LOWER |=> state_r.sh == IDENT_LOWER;
   endproperty
   a_ident_lower: assert property (p_ident_lower)
      else $error("lower identifier wrong");

   property p_advert_write;
      logic [2:0]  pi;
      logic [15:0] d;
      (wr_commit, pi = cur_pidx, d = wr_data)
         |=> (state_r.adv[pi] & ADV_WRITE_MASK) == (d & ADV_WRITE_MASK);
   endproperty
   a_advert_write: assert property (p_advert_write)
      else $error("ability write not stored");

   property p_selector;
      sel_ok;
   endproperty
   a_selector: assert property (p_selector)
      else $error("selector field changed");

   property p_partner_zero;
      lp_zero_ok;
   endproperty
   a_partner_zero: assert property (p_partner_zero)
      else $error("partner reserved bits set");

   property p_partner_hold;
      partner_page_valid_in == '0 |=> $stable(state_r.lp);
   endproperty
   a_partner_hold: assert property (p_partner_hold)
      else $error("partner bits changed without a page");

   property p_partner_load;
      partner_page_valid_in[0]
         |=> state_r.lp[0] == ($past(partner_page_in[15:0]) & PARTNER_MASK);
   endproperty
   a_partner_load: assert property (p_partner_load)
      else $error("partner bits not captured");

   property p_far_address;
      hdr_done && !state_nxt.hit |=> (!state_r.oe) [*8];
   endproperty
   a_far_address: assert property (p_far_address)
      else $error("pin driven for a foreign frame");

   sequence s_read_hit;
      hdr_done && state_nxt.hit && state_nxt.rd;
   endsequence

   sequence s_turn_drive;
      state_r.oe && !state_r.out && state_r.st == TURN;
   endsequence

   property p_read_answer;
      s_read_hit |-> ##[1:40] s_turn_drive;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("no turnaround drive for own read");
endmodule

// File: bench/mgmt_ctrl_model.sv
// Station management controller model for the serial pins.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module mgmt_ctrl_model (
   // Clock
   input  wire logic clk_in,
   // Management pins
   input  wire logic mdio_in,
   output logic      mdc_out,
   output logic      mdio_out,
   output logic      mdio_oe_out
);
   // Extra ones so a refused frame's skip never eats the preamble
   localparam int PRE = 48;

   initial
   begin
      mdc_out     = 1'b0;
      mdio_out    = 1'b1;
      mdio_oe_out = 1'b0;
   end

   // Bit time of 8 clk: data set while low, wire sampled at the rise
   task automatic bit_time(input logic oe, input logic d, output logic s);
      @(posedge clk_in);
      #1;
      mdc_out     = 1'b0;
      mdio_oe_out = oe;
      mdio_out    = oe ? d : ~mdio_out;
      repeat (4) @(posedge clk_in);
      #1;
      mdc_out = 1'b1;
      s       = mdio_in;
      repeat (3) @(posedge clk_in);
   endtask

   // Whole frame; hdr is start and op, released from turnaround on read
   task automatic frame(input logic [3:0] hdr, input logic [4:0] port,
                        input logic [4:0] rg, input logic [15:0] wd,
                        output logic [15:0] rd);
      logic        s;
      logic        rdn;
      logic [31:0] word;
      rd   = 16'h0000;
      rdn  = (hdr == 4'b0110);
      word = {hdr, port, rg, 2'b10, wd};
      for (int i = 0; i < PRE; i++)
         bit_time(1'b1, 1'b1, s);
      for (int i = 31; i >= 0; i--)
      begin
         bit_time(!(rdn && i < 18), word[i], s);
         if (i < 16)
            rd[i] = s;
      end
      // Clock stands still between frames
      @(posedge clk_in);
      #1;
      mdc_out     = 1'b0;
      mdio_oe_out = 1'b0;
   endtask
endmodule

// File: bench/mgmt_port_regs_bench.sv
// Self-checking bench for the management register slave.
// Assumes the controller model drives the pins, pull-up on data.
`timescale 1ns/1ps
module mgmt_port_regs_bench
   import mgmt_regs_pkg::*;
;
   // Arbitrary identifier values
   localparam logic [15:0] ID_UP = 16'h5a3c;
   localparam logic [15:0] ID_LO = 16'hc3a0;

   logic        clk_in;
   logic        rstn_in;
   logic        mdc;
   logic        mdio_wire;
   logic        slave_dout;
   logic        slave_oe;
   logic        ctrl_dat;
   logic        ctrl_oe;
   logic [4:0]  link_up;
   logic [4:0]  page_valid;
   logic [79:0] page;
   logic [79:0] advert;
   logic        oe_seen;
   int          err_count;
   int          compares;
   int          p;
   int          abil [5] = '{10, 8, 7, 6, 5};
   logic [15:0] d;

   // Released wire floats high through the pull-up
   assign mdio_wire = slave_oe ? slave_dout : (ctrl_oe ? ctrl_dat : 1'b1);

   mgmt_port_regs #(
      .IDENT_UPPER (ID_UP),
      .IDENT_LOWER (ID_LO)
   ) i_mgmt_port_regs (
      .clk_in                (clk_in),
      .rstn_in               (rstn_in),
      .mdc_in                (mdc),
      .mdio_in               (mdio_wire),
      .mdio_out              (slave_dout),
      .mdio_oe_out           (slave_oe),
      .link_up_in            (link_up),
      .partner_page_valid_in (page_valid),
      .partner_page_in       (page),
      .local_advert_out      (advert)
   );

   mgmt_ctrl_model i_mgmt_ctrl_model (
      .clk_in      (clk_in),
      .mdio_in     (mdio_wire),
      .mdc_out     (mdc),
      .mdio_out    (ctrl_dat),
      .mdio_oe_out (ctrl_oe)
   );

   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   // Drive window watch; both parties driving is a turnaround fault
   // Falling edge, so registered enables are settled when looked at
   always @(negedge clk_in)
   begin
      if (slave_oe === 1'b1)
         oe_seen <= 1'b1;
      if (slave_oe === 1'b1 && ctrl_oe === 1'b1)
      begin
         err_count++;
         $display("BAD wire contention expected 0 seen 1");
      end
   end

   task automatic stop_test();
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp,
                      input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic do_reset();
      @(posedge clk_in);
      #1;
      rstn_in = 1'b0;
      repeat (16) @(posedge clk_in);
      #1;
      rstn_in = 1'b1;
      repeat (3) @(posedge clk_in);
   endtask

   // Read; the slave must drive only for a valid port and register
   task automatic rd(input logic [4:0] port, input logic [4:0] rg,
                     input logic [15:0] exp);
      logic ok;
      ok      = port >= 5'h01 && port <= 5'h05 && rg <= 5'h05;
      oe_seen = 1'b0;
      i_mgmt_ctrl_model.frame(4'b0110, port, rg, 16'h0000, d);
      chk("read data", exp, d);
      chk("slave drove", {15'h0000, ok}, {15'h0000, oe_seen});
   endtask

   task automatic wr(input logic [4:0] port, input logic [4:0] rg,
                     input logic [15:0] wd);
      i_mgmt_ctrl_model.frame(4'b0101, port, rg, wd, d);
   endtask

   task automatic page_in(input int q, input logic [15:0] w);
      @(posedge clk_in);
      #1;
      page[(q-1)*16 +: 16] = w;
      page_valid[q-1]      = 1'b1;
      @(posedge clk_in);
      #1;
      page_valid[q-1] = 1'b0;
   endtask

   initial
   begin
      repeat (95000) @(posedge clk_in);
      err_count++;
      stop_test();
   end

   initial
   begin
      rstn_in    = 1'b0;
      link_up    = 5'h00;
      page_valid = 5'h00;
      page       = '0;
      oe_seen    = 1'b0;
      err_count  = 0;
      compares   = 0;
      do_reset();
      for (p = 1; p <= 5; p++)
      begin
         chk("advert out", 16'h05e1, advert[(p-1)*16 +: 16]);
         rd(5'(p), REG_ADVERT, 16'h05e1);
         rd(5'(p), REG_PARTNER, 16'h0000);
         rd(5'(p), REG_STATUS, 16'h0000);
         rd(5'(p), REG_IDENT_UPPER, ID_UP);
         rd(5'(p), REG_IDENT_LOWER, ID_LO);
      end
      wr(5'h01, REG_IDENT_UPPER, ~ID_UP);
      wr(5'h01, REG_IDENT_LOWER, ~ID_LO);
      wr(5'h01, REG_PARTNER, 16'hffff);
      rd(5'h01, REG_IDENT_UPPER, ID_UP);
      rd(5'h01, REG_IDENT_LOWER, ID_LO);
      rd(5'h01, REG_PARTNER, 16'h0000);
      // One ability bit at a time, non-ability page bits set to expose leaks
      for (int i = 0; i < 5; i++)
      begin
         wr(5'h02, REG_ADVERT, 16'h0001 << abil[i]);
         rd(5'h02, REG_ADVERT, (16'h0001 << abil[i]) | 16'h0001);
         chk("advert out", (16'h0001 << abil[i]) | 16'h0001,
             advert[16 +: 16]);
         page_in(4, 16'hfa1f | (16'h0001 << abil[i]));
         rd(5'h04, REG_PARTNER, 16'h0001 << abil[i]);
      end
      wr(5'h02, REG_ADVERT, 16'hfa1e);
      rd(5'h02, REG_ADVERT, 16'h0001);
      chk("advert out", 16'h05e1, advert[0 +: 16]);
      page_in(4, 16'hffff);
      page[48 +: 16] = 16'h0000;
      rd(5'h04, REG_PARTNER, 16'h05e0);
      rd(5'h05, REG_PARTNER, 16'h0000);
      page_in(1, 16'hffff);
      rd(5'h01, REG_PARTNER, 16'h05e0);
      rd(5'h01, REG_CONTROL, 16'h0000);
      link_up = 5'b00100;
      rd(5'h03, REG_STATUS, 16'h0004);
      rd(5'h04, REG_STATUS, 16'h0000);
      link_up = 5'b00000;
      rd(5'h03, REG_STATUS, 16'h0000);
      rd(5'h00, REG_IDENT_UPPER, 16'hffff);
      rd(5'h06, REG_IDENT_UPPER, 16'hffff);
      rd(5'h01, 5'h06, 16'hffff);
      i_mgmt_ctrl_model.frame(4'b0001, 5'h01, REG_ADVERT,
                              16'h0000, d);
      i_mgmt_ctrl_model.frame(4'b0100, 5'h01, REG_ADVERT,
                              16'h0000, d);
      rd(5'h01, REG_ADVERT, 16'h05e1);
      // Mid-run reset must restore defaults
      do_reset();
      chk("advert out", 16'h05e1, advert[16 +: 16]);
      rd(5'h02, REG_ADVERT, 16'h05e1);
      rd(5'h04, REG_PARTNER, 16'h0000);
      stop_test();
   end
endmodule
